/* shared/scg_consts.vh */
// constants for the sleep-mode clock gating register block
// assumes a single 32-bit register space reached over axi4-lite
`ifndef SCG_CONSTS_VH
`define SCG_CONSTS_VH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define SCG_BASE_ADDR 32'h400fe000
`define SCG_OFF_SLEEP 12'h118
`define SCG_OFF_STAT 12'h1f0
`define SCG_OFF_MASK 12'h1f4
`define SCG_OFF_EFF 12'h1f8

// ----------------------------------------------------------------
// field positions of the gating register
// ----------------------------------------------------------------
`define SCG_BIT_PHY 30
`define SCG_BIT_MAC 28
`define SCG_BIT_PORT_G 6
`define SCG_BIT_PORT_A 0
`define SCG_DEF_MASK 32'h5000007f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCG_RST_SLEEP 32'h00000000
`define SCG_RST_STAT 9'h000
`define SCG_RST_MASK 9'h000

// ----------------------------------------------------------------
// bus answers and decode codes
// ----------------------------------------------------------------
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2
`define SCG_SEL_NONE 2'h0
`define SCG_SEL_SLEEP 2'h1
`define SCG_SEL_STAT 2'h2
`define SCG_SEL_MASK 2'h3

`endif

/* rtl/scg_sleep_clock_gate.v */
// sleep-mode clock gating register with axi4-lite slave, effective
// enable selection, unit bus-fault flagging and a fault interrupt.
// assumes the run-mode and deep-sleep enables, the auto gating select
// and the power state come from logic on clk_sys; enables drive
// downstream clock gating cells, which latch them glitch-free.
`timescale 1ns/1ps
`include "scg_consts.vh"

module scg_sleep_clock_gate #(
	parameter ADDR_W = 32
) (
	input wire clk_sys,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] runGateIn,
	input wire [31:0] deepGateIn,
	input wire autoClockGateSelect,
	input wire sleepActive,
	input wire deepSleepActive,
	input wire [8:0] unitAccess,
	output reg [8:0] unitFault,
	output reg ethPhyClockEnable,
	output reg ethMacClockEnable,
	output reg [6:0] portClockEnable,
	output reg irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// address decode, used by both the write and the read path
	function [1:0] regSel;
		input [ADDR_W-1:0] addr;
		begin
			if (addr == (`SCG_BASE_ADDR + `SCG_OFF_SLEEP)) begin
				regSel = `SCG_SEL_SLEEP;
			end else if (addr == (`SCG_BASE_ADDR + `SCG_OFF_STAT)) begin
				regSel = `SCG_SEL_STAT;
			end else if (addr == (`SCG_BASE_ADDR + `SCG_OFF_MASK)) begin
				regSel = `SCG_SEL_MASK;
			end else begin
				regSel = `SCG_SEL_NONE;
			end
		end
	endfunction

	// byte-lane merge of a write into an old word
	function [31:0] laneMerge;
		input [31:0] oldWord;
		input [31:0] newWord;
		input [3:0] strb;
		integer i;
		begin
			laneMerge = oldWord;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					laneMerge[i*8 +: 8] = newWord[i*8 +: 8];
				end
			end
		end
	endfunction

	// nine defined enables in register layout packed to {phy, mac, g..a}
	function [8:0] packEn;
		input [31:0] word;
		begin
			packEn = {word[`SCG_BIT_PHY], word[`SCG_BIT_MAC], word[`SCG_BIT_PORT_G:`SCG_BIT_PORT_A]};
		end
	endfunction

	function [31:0] unpackEn;
		input [8:0] en;
		begin
			unpackEn = 32'h00000000;
			unpackEn[`SCG_BIT_PHY] = en[8];
			unpackEn[`SCG_BIT_MAC] = en[7];
			unpackEn[`SCG_BIT_PORT_G:`SCG_BIT_PORT_A] = en[6:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [31:0] sleepGate_reg;
	reg [8:0] faultStat_reg;
	reg [8:0] faultMask_reg;
	reg [8:0] effEn_reg;
	reg awHeld_reg;
	reg wHeld_reg;
	reg [ADDR_W-1:0] awAddr_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;

	wire doWrite;
	wire [1:0] wrSel;
	wire [1:0] rdSel;
	reg [8:0] effEn_next;
	reg [8:0] faultStat_next;
	reg [31:0] rdWord;
	wire [31:0] maskMerged;

	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign wrSel = regSel(awAddr_reg);
	assign rdSel = regSel(s_axi_araddr);
	assign maskMerged = laneMerge({23'h000000, faultMask_reg}, wData_reg, wStrb_reg);

	// ----------------------------------------------------------------
	// effective enable selection
	// ----------------------------------------------------------------
	// only the selected mode's word reaches the flops; the registered
	// result changes once per edge, so the gating cells see no glitch
	always @* begin
		effEn_next = packEn(runGateIn);
		if (autoClockGateSelect && deepSleepActive) begin
			effEn_next = packEn(deepGateIn);
		end else if (autoClockGateSelect && sleepActive) begin
			effEn_next = packEn(sleepGate_reg);
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			effEn_reg <= 9'h000;
			ethPhyClockEnable <= 1'b0;
			ethMacClockEnable <= 1'b0;
			portClockEnable <= 7'h00;
		end else begin
			effEn_reg <= effEn_next;
			ethPhyClockEnable <= effEn_next[8];
			ethMacClockEnable <= effEn_next[7];
			portClockEnable <= effEn_next[6:0];
		end
	end

	// ----------------------------------------------------------------
	// bus fault on access to an unclocked unit
	// ----------------------------------------------------------------
	always @* begin
		// a new fault wins over a write-one clear in the same cycle
		faultStat_next = faultStat_reg;
		if (doWrite && (wrSel == `SCG_SEL_STAT)) begin
			faultStat_next = faultStat_reg & ~{wStrb_reg[1] & wData_reg[8], wData_reg[7:0] & {8{wStrb_reg[0]}}};
		end
		faultStat_next = faultStat_next | (unitAccess & ~effEn_reg);
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			unitFault <= 9'h000;
			faultStat_reg <= `SCG_RST_STAT;
			irq <= 1'b0;
		end else begin
			unitFault <= unitAccess & ~effEn_reg;
			faultStat_reg <= faultStat_next;
			irq <= |(faultStat_next & faultMask_reg);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	// address and data are taken in either order; the write lands one
	// edge after both are held, and bvalid rises at that same edge
	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCG_RESP_OKAY;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= {ADDR_W{1'b0}};
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			sleepGate_reg <= `SCG_RST_SLEEP;
			faultMask_reg <= `SCG_RST_MASK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wrSel == `SCG_SEL_NONE) ? `SCG_RESP_SLVERR : `SCG_RESP_OKAY;
				if (wrSel == `SCG_SEL_SLEEP) begin
					// reserved bits never store, so they always read zero
					sleepGate_reg <= laneMerge(sleepGate_reg, wData_reg, wStrb_reg) & `SCG_DEF_MASK;
				end
				if (wrSel == `SCG_SEL_MASK) begin
					faultMask_reg <= maskMerged[8:0];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	always @* begin
		case (rdSel)
			`SCG_SEL_SLEEP: begin
				rdWord = sleepGate_reg & `SCG_DEF_MASK;
			end
			`SCG_SEL_STAT: begin
				rdWord = {23'h000000, faultStat_reg};
			end
			`SCG_SEL_MASK: begin
				rdWord = {23'h000000, faultMask_reg};
			end
			default: begin
				rdWord = 32'h00000000;
			end
		endcase
		// effective enables in register layout, read-only
		if (s_axi_araddr == (`SCG_BASE_ADDR + `SCG_OFF_EFF)) begin
			rdWord = unpackEn(effEn_reg);
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SCG_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdWord;
				if ((rdSel == `SCG_SEL_NONE) && (s_axi_araddr != (`SCG_BASE_ADDR + `SCG_OFF_EFF))) begin
					s_axi_rresp <= `SCG_RESP_SLVERR;
				end else begin
					s_axi_rresp <= `SCG_RESP_OKAY;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // scg_sleep_clock_gate

/* sim/scg_props.sv */
// checker: port assertions of the gating block
// assumes one clock and a sync active-high rst
`timescale 1ns/1ps
`include "scg_consts.vh"
module scg_props #(
	parameter ADDR_W = 32
) (
	input wire clk_sys,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire [31:0] runGateIn,
	input wire [31:0] deepGateIn,
	input wire autoClockGateSelect,
	input wire deepSleepActive,
	input wire [8:0] unitAccess,
	input wire [8:0] unitFault,
	input wire ethPhyClockEnable,
	input wire ethMacClockEnable,
	input wire [6:0] portClockEnable
);
	wire [8:0] en = {ethPhyClockEnable, ethMacClockEnable, portClockEnable};
	wire arTake = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	fault_match_a: assert property (!$past(rst) |-> unitFault == $past(unitAccess & ~en))
		else $error("bad fault");
	reset_zero_a: assert property ($past(rst) |-> en == 9'h0)
		else $error("bad reset");
	run_ports_a: assert property (!autoClockGateSelect |=> portClockEnable == $past(runGateIn[6:0]))
		else $error("bad ports");
	run_phy_a: assert property (!autoClockGateSelect |=> ethPhyClockEnable == $past(runGateIn[30]))
		else $error("bad phy");
	run_mac_a: assert property (!autoClockGateSelect |=> ethMacClockEnable == $past(runGateIn[28]))
		else $error("bad mac");
	deep_ports_a: assert property (autoClockGateSelect && deepSleepActive
		|=> portClockEnable == $past(deepGateIn[6:0])) else $error("bad deep");
	gate_read_a: assert property (arTake && s_axi_araddr == `SCG_BASE_ADDR + `SCG_OFF_SLEEP
		|=> s_axi_rresp == `SCG_RESP_OKAY && (s_axi_rdata & ~`SCG_DEF_MASK) == 32'h0) else $error("bad read");
	unmapped_read_a: assert property (arTake && s_axi_araddr == `SCG_BASE_ADDR + 32'h200
		|=> s_axi_rresp == `SCG_RESP_SLVERR) else $error("no slverr");
	cover property (unitFault != 9'h0);
	cover property (autoClockGateSelect && deepSleepActive);
	cover property (arTake);
endmodule // scg_props

bind scg_sleep_clock_gate scg_props #(.ADDR_W(ADDR_W)) scg_props_i (.clk_sys, .rst, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .runGateIn, .deepGateIn, .autoClockGateSelect,
	.deepSleepActive, .unitAccess, .unitFault, .ethPhyClockEnable, .ethMacClockEnable, .portClockEnable);

/* sim/scg_unit_side.sv */
// unit-side model: the gated units trying bus accesses
// assumes the bench raises fire for one cycle
`timescale 1ns/1ps
module scg_unit_side (
	input wire clk_sys,
	input wire fire,
	input wire [3:0] unitSel,
	output reg [8:0] unitAccess
);
	// an attempt lasts one cycle, like an address phase
	always @(posedge clk_sys) begin
		unitAccess <= fire ? 9'h1 << unitSel : 9'h0;
	end
endmodule // scg_unit_side

/* sim/testbench.sv */
// testbench: register and unit fault tests of the gating block
// assumes the unit-side model and the bound checker
`timescale 1ns/1ps
`include "scg_consts.vh"
module testbench;
	localparam [31:0] SLP = `SCG_BASE_ADDR + `SCG_OFF_SLEEP;
	localparam [31:0] STA = `SCG_BASE_ADDR + `SCG_OFF_STAT;
	reg clk_sys = 1'h0;
	reg rst = 1'h1;
	reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, runGateIn = 32'h0, deepGateIn = 32'h0;
	reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg autoClockGateSelect = 1'h0, sleepActive = 1'h0, deepSleepActive = 1'h0, fire = 1'h0;
	reg [3:0] unitSel = 4'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ethPhyClockEnable, ethMacClockEnable, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [8:0] unitAccess, unitFault;
	wire [6:0] portClockEnable;
	wire [31:0] effW = {1'h0, ethPhyClockEnable, 1'h0, ethMacClockEnable, 21'h0, portClockEnable};
	reg [31:0] got;
	int n_errors = 0;
	int num_checks = 0;
	int n;
	initial forever #20 clk_sys = ~clk_sys;
	scg_sleep_clock_gate scg_sleep_clock_gate_i (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.runGateIn, .deepGateIn, .autoClockGateSelect, .sleepActive, .deepSleepActive, .unitAccess, .unitFault,
		.ethPhyClockEnable, .ethMacClockEnable, .portClockEnable, .irq);
	scg_unit_side scg_unit_side_i (.clk_sys, .fire, .unitSel, .unitAccess);
	task results;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h wanted %h", $time, g, e);
		end
	endtask
	task bounded;
		if (n >= 50) begin
			n_errors++;
			$display("Error at %0t: no answer", $time);
			results();
		end
	endtask
	task wr(input [31:0] a, input [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			n++;
		end while (s_axi_bvalid !== 1'h1 && n < 50);
		s_axi_bready <= 1'h0;
		got = {s_axi_bresp, 30'h0};
		bounded();
	endtask
	// got carries rresp in its top bits so one compare covers both
	task rd(input [31:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			n++;
		end while (s_axi_rvalid !== 1'h1 && n < 50);
		s_axi_rready <= 1'h0;
		got = s_axi_rdata | {s_axi_rresp, 30'h0};
		bounded();
	endtask
	task hit(input [3:0] u);
		@(posedge clk_sys);
		unitSel <= u;
		fire <= 1'h1;
		@(posedge clk_sys);
		fire <= 1'h0;
		repeat (2) @(posedge clk_sys);
	endtask
	task eff(input [31:0] e);
		repeat (2) @(posedge clk_sys);
		chk(effW, e);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'h0;
		rd(SLP);
		chk(got, `SCG_RST_SLEEP);
		wr(SLP, 32'hffffffff);
		chk(got, {`SCG_RESP_OKAY, 30'h0});
		rd(SLP);
		chk(got, `SCG_DEF_MASK);
		s_axi_wstrb <= 4'h1;
		wr(SLP, 32'h0);
		s_axi_wstrb <= 4'hf;
		rd(SLP);
		chk(got, 32'h50000000);
		wr(SLP, 32'hffffffff);
		wr(`SCG_BASE_ADDR + `SCG_OFF_EFF, 32'h0);
		chk(got, {`SCG_RESP_SLVERR, 30'h0});
		rd(`SCG_BASE_ADDR + 32'h200);
		chk(got, {`SCG_RESP_SLVERR, 30'h0});
		runGateIn <= 32'h10000005;
		eff(32'h10000005);
		autoClockGateSelect <= 1'h1;
		sleepActive <= 1'h1;
		eff(`SCG_DEF_MASK);
		wr(SLP, 32'h40000041);
		eff(32'h40000041);
		rd(`SCG_BASE_ADDR + `SCG_OFF_EFF);
		chk(got, 32'h40000041);
		hit(4'h1);
		chk({31'h0, irq}, 32'h0);
		rd(STA);
		chk(got, 32'h2);
		wr(`SCG_BASE_ADDR + `SCG_OFF_MASK, 32'h1ff);
		eff(32'h40000041);
		chk({31'h0, irq}, 32'h1);
		wr(STA, 32'h2);
		hit(4'h8);
		chk({31'h0, irq}, 32'h0);
		deepGateIn <= 32'h10000020;
		deepSleepActive <= 1'h1;
		eff(32'h10000020);
		autoClockGateSelect <= 1'h0;
		eff(32'h10000005);
		results();
	end
endmodule // testbench
